// [bench/vic_cpu_model.sv]
/*
 CPU core stand-in: presents the core priority level and takes the
 vector address when a new request appears.
 Assumes the bench chooses the level; one clock with the controller.
*/
`timescale 1ns/100ps
module vic_cpu_model
    import vic_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // Controller side
    input  wire logic              irq_req,
    input  wire logic [PC_W-1:0]   irq_vector_addr,
    output logic      [LVL_W-1:0]  cpu_priority_level,
    // Bench side
    input  wire logic [LVL_W-1:0]  set_level,
    output logic      [PC_W-1:0]   taken_addr
);
    logic req_d;

    // =========================================================
    // Vector fetch on a fresh request, no acknowledge back
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            req_d      <= 1'h0;
            taken_addr <= 24'h000000;
        end else begin
            req_d <= irq_req;
            if (irq_req && !req_d) begin
                taken_addr <= irq_vector_addr;
            end
        end
    end

    // Level is software state of the core, mirrored from bench
    assign cpu_priority_level = set_level;
endmodule : vic_cpu_model

// [bench/vic_top_tb_top.sv]
/*
 Self-checking bench of the interrupt controller: Avalon tasks and
 one task per scenario. Assumes the core model and the rtl compiled.
*/
`timescale 1ns/100ps
module vic_top_tb_top
    import vic_pkg::*;
;
    logic                clk        = 1'h0;
    logic                sys_rst    = 1'h1;
    logic [ADDR_W-1:0]   address    = '0;
    logic                read       = 1'h0;
    logic                write      = 1'h0;
    logic [DATA_W-1:0]   writedata  = '0;
    logic [DATA_W-1:0]   readdata;
    logic                waitrequest;
    logic [NUM_SRC-1:0]  src_event  = '0;
    logic                ext_pin    = 1'h0;
    logic [NUM_TRAP-1:0] trap_event = '0;
    logic [LVL_W-1:0]    cpu_lvl;
    logic [LVL_W-1:0]    set_level  = '0;
    logic                irq_req;
    logic                irq_is_trap;
    logic [VEC_W-1:0]    irq_vector_num;
    logic [LVL_W-1:0]    irq_level;
    logic [PC_W-1:0]     irq_vector_addr;
    logic [PC_W-1:0]     taken_addr;
    int                  n_fail     = 0;
    int                  cmp_count  = 0;

    // =========================================================
    // Clock, 5 ns period
    always #2.5 clk = ~clk;

    vic_top #(.N(NUM_SRC)) dut_u (
        .clk(clk), .sys_rst(sys_rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .src_event(src_event),
        .external_request_zero(ext_pin), .trap_event(trap_event),
        .cpu_priority_level(cpu_lvl), .irq_req(irq_req),
        .irq_is_trap(irq_is_trap), .irq_vector_num(irq_vector_num),
        .irq_level(irq_level), .irq_vector_addr(irq_vector_addr));

    vic_cpu_model cpu_u (
        .clk(clk), .sys_rst(sys_rst), .irq_req(irq_req),
        .irq_vector_addr(irq_vector_addr), .cpu_priority_level(cpu_lvl),
        .set_level(set_level), .taken_addr(taken_addr));

    // =========================================================
    // Reporting
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    // =========================================================
    // Bus and stimulus helpers
    // Held until the rising edge at which waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [15:0] d, output logic [15:0] q);
        logic ws;
        int   k;
        @(posedge clk);
        address   <= a;
        writedata <= d;
        read      <= !wr;
        write     <= wr;
        ws = 1'h1;
        for (k = 0; k < 20 && ws; k++) begin
            @(posedge clk);
            ws = waitrequest;
            q  = readdata;
        end
        read  <= 1'h0;
        write <= 1'h0;
        if (ws) begin
            n_fail++;
            summarize();
        end
    endtask : bus

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        logic [15:0] q;
        bus(1'h1, a, d, q);
    endtask : wr

    task automatic rd(input logic [5:0] a, output logic [15:0] q);
        bus(1'h0, a, 16'h0000, q);
    endtask : rd

    // Two edges: register lands, then the request flop follows
    task automatic settle();
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic level(input logic [3:0] l);
        @(posedge clk);
        set_level <= l;
        settle();
    endtask : level

    task automatic pulse(input int n);
        @(posedge clk);
        src_event[n] <= 1'h1;
        @(posedge clk);
        src_event <= '0;
    endtask : pulse

    task automatic tpulse(input int n);
        @(posedge clk);
        trap_event[n] <= 1'h1;
        @(posedge clk);
        trap_event <= '0;
        settle();
    endtask : tpulse

    // Enable source n and give it priority p, read-modify-write
    task automatic arm(input int n, input logic [2:0] p);
        logic [15:0] q;
        rd(6'(REG_EN_BASE + n / 16), q);
        wr(6'(REG_EN_BASE + n / 16), q | (16'h0001 << (n % 16)));
        rd(6'(REG_PRIO_BASE + n / 4), q);
        q[4 * (n % 4) +: 3] = p;
        wr(6'(REG_PRIO_BASE + n / 4), q);
    endtask : arm

    task automatic clear_all();
        for (int i = 0; i < 8; i++) begin
            wr(6'(REG_FLAG_BASE + i), 16'h0000);
            wr(6'(REG_EN_BASE + i), 16'h0000);
        end
    endtask : clear_all

    task automatic chk_irq(input logic r, input logic t,
                           input logic [6:0] v, input logic [3:0] l,
                           input logic [23:0] a);
        check("irq_req", 32'(irq_req), 32'(r));
        check("irq_is_trap", 32'(irq_is_trap), 32'(t));
        check("irq_vector_num", 32'(irq_vector_num), 32'(v));
        check("irq_level", 32'(irq_level), 32'(l));
        check("irq_vector_addr", 32'(irq_vector_addr), 32'(a));
    endtask : chk_irq

    // =========================================================
    // Scenarios
    task automatic t_reset();
        logic [15:0] q;
        chk_irq(1'h0, 1'h0, 7'h00, 4'h0, 24'h000000);
        rd(REG_CTRL_TWO, q);
        check("ctrl_two", 32'(q), 32'h0);
        rd(6'h3F, q);
        check("unmapped", 32'(q), 32'h0);
    endtask : t_reset

    task automatic t_timer();
        logic [15:0] q;
        arm(3, 3'h5);
        pulse(3);
        @(negedge clk);
        check("req after one", 32'(irq_req), 32'h0);
        @(negedge clk);
        chk_irq(1'h1, 1'h0, 7'h0B, 4'h5, 24'h00001A);
        @(negedge clk);
        check("taken", 32'(taken_addr), 32'h1A);
        rd(REG_FLAG_BASE, q);
        check("flag sticky", 32'(q), 32'h8);
        rd(REG_PENDING, q);
        check("pending reg", 32'(q), 32'h050B);
        wr(REG_CTRL_TWO, 16'h8000);
        settle();
        check("alt addr", 32'(irq_vector_addr), 32'h11A);
        wr(REG_CTRL_TWO, 16'h0000);
        settle();
        check("primary addr", 32'(irq_vector_addr), 32'h1A);
        wr(REG_FLAG_BASE, 16'h0000);
        settle();
        check("cleared", 32'(irq_req), 32'h0);
    endtask : t_timer

    // Equal levels, then raised level, then last source
    task automatic t_arb();
        logic [15:0] q;
        arm(0, 3'h3);
        arm(1, 3'h3);
        wr(REG_FLAG_BASE, 16'h0003);
        settle();
        chk_irq(1'h1, 1'h0, 7'h08, 4'h3, 24'h000014);
        arm(1, 3'h6);
        settle();
        chk_irq(1'h1, 1'h0, 7'h09, 4'h6, 24'h000016);
        arm(117, 3'h7);
        pulse(117);
        settle();
        chk_irq(1'h1, 1'h0, 7'h7D, 4'h7, 24'h0000FE);
        rd(6'(REG_FLAG_BASE + 7), q);
        check("flag 117", 32'(q), 32'h20);
    endtask : t_arb

    task automatic t_level();
        level(4'h7);
        check("level seven", 32'(irq_req), 32'h0);
        level(4'h6);
        chk_irq(1'h1, 1'h0, 7'h7D, 4'h7, 24'h0000FE);
        arm(117, 3'h6);
        settle();
        check("equal level", 32'(irq_req), 32'h0);
        level(4'h0);
        arm(117, 3'h0);
        arm(1, 3'h0);
        arm(0, 3'h0);
        settle();
        check("prio zero", 32'(irq_req), 32'h0);
    endtask : t_level

    // Traps 1 to 4 each pre-empt a top-level user source, then hand back
    task automatic t_traps();
        logic [15:0] q;
        arm(2, 3'h7);
        wr(REG_FLAG_BASE, 16'h0004);
        for (int n = 1; n <= 4; n++) begin
            tpulse(n);
            chk_irq(1'h1, 1'h1, 7'(n), 4'(15 - n), 24'(4 + 2 * n));
            rd(REG_CTRL_ONE, q);
            check("trap status", 32'(q), 32'(1 << n));
            wr(REG_CTRL_ONE, 16'h0000);
            settle();
            chk_irq(1'h1, 1'h0, 7'h0A, 4'h7, 24'h000018);
        end
        level(4'h7);
        wr(REG_CTRL_TWO, 16'h8000);
        tpulse(1);
        chk_irq(1'h1, 1'h1, 7'h01, 4'hE, 24'h000106);
        wr(REG_CTRL_ONE, 16'h0000);
        wr(REG_CTRL_TWO, 16'h0000);
        level(4'h0);
    endtask : t_traps

    task automatic t_ext();
        logic [15:0] q;
        int          k;
        arm(0, 3'h4);
        @(posedge clk);
        ext_pin <= 1'h1;
        for (k = 0; k < 12 && irq_req !== 1'h1; k++) begin
            @(negedge clk);
        end
        if (irq_req !== 1'h1) begin
            n_fail++;
            summarize();
        end
        chk_irq(1'h1, 1'h0, 7'h08, 4'h4, 24'h000014);
        @(posedge clk);
        ext_pin <= 1'h0;
        rd(REG_FLAG_BASE, q);
        check("ext flag", 32'(q), 32'h1);
    endtask : t_ext

    // =========================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'h0;
        @(negedge clk);
        t_reset();
        t_timer();
        clear_all();
        t_arb();
        t_level();
        clear_all();
        t_traps();
        clear_all();
        t_ext();
        summarize();
    end
endmodule : vic_top_tb_top

// [rtl/vic_arbiter.sv]
/*
 User arbitration: highest priority, then lowest source number.
 Assumes pending already gated by enable and CPU level.
*/
`timescale 1ns/100ps
module vic_arbiter
    import vic_pkg::*;
#(
    parameter int N = NUM_SRC
) (
    // Candidates
    input  wire logic [N-1:0]             pend,
    input  wire logic [N-1:0][PRIO_W-1:0] prio,
    // Winner
    output logic                          win,
    output logic      [VEC_W-1:0]         win_idx,
    output logic      [PRIO_W-1:0]        win_lvl
);
    // Scan downward; ">=" lets the lower number take equal levels
    always_comb begin
        win     = 1'b0;
        win_idx = '0;
        win_lvl = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend[i] && prio[i] >= win_lvl) begin
                win     = 1'b1;
                win_idx = VEC_W'(i);
                win_lvl = prio[i];
            end
        end
    end
endmodule : vic_arbiter

// [rtl/vic_pkg.sv]
/*
 Constants of the vectored interrupt controller: sizes, register
 indices, field positions, table addresses, levels.
 Assumes the CPU core and peripherals share the system clock.
*/
// Overview of operation
// - All requests merge into one CPU request
// - Each source gets software priority one to seven
// - Same level: lower vector number wins
// - Primary table at 000004h, 126 entries
// - Each entry is a 24-bit handler address
// - Select bit 15 switches all to alternate
// - Alternate entry equals primary address plus 100h
// - Eight unmaskable trap vectors come first
// - Trap n at 000004h plus 2n
// - Interrupt vector v at 000014h plus 2v
// - Reset clears registers, bypasses the controller
// - Each source has flag, enable, priority
// - Timer one uses vector 3, 00001Ah
// - Fixed entry latency independent of data
// - Flags set by events, cleared by software
// - Winner number and level latched, readable
// - CPU level seven blocks user interrupts
package vic_pkg;
    // ==========================================================
    // Sizes
    localparam int NUM_SRC  = 118;
    localparam int NUM_TRAP = 8;
    localparam int DATA_W   = 16;
    localparam int ADDR_W   = 6;
    localparam int PRIO_W   = 3;
    localparam int LVL_W    = 4;
    localparam int VEC_W    = 7;
    localparam int PC_W     = 24;
    localparam int SRC_PER_REG  = 16;
    localparam int PRIO_PER_REG = 4;
    localparam int PRIO_STRIDE  = 4;

    // ==========================================================
    // Register word indices
    localparam logic [5:0] REG_FLAG_BASE = 6'h00;
    localparam logic [5:0] REG_EN_BASE   = 6'h08;
    localparam logic [5:0] REG_PRIO_BASE = 6'h10;
    localparam logic [5:0] REG_CTRL_ONE  = 6'h30;
    localparam logic [5:0] REG_CTRL_TWO  = 6'h31;
    localparam logic [5:0] REG_PENDING   = 6'h32;

    // ==========================================================
    // Field positions and reset values
    localparam int ALT_SEL_BIT   = 15;
    localparam int NEST_DIS_BIT  = 15;
    localparam int PEND_LVL_LSB  = 8;
    localparam logic [7:0] TRAP_IMPL_MASK = 8'h1E;
    localparam logic [15:0] CTRL_RESET   = 16'h0000;

    // ==========================================================
    // Table addresses and levels
    localparam logic [23:0] PRIMARY_BASE = 24'h000004;
    localparam logic [23:0] ALT_OFFSET   = 24'h000100;
    localparam logic [23:0] RESET_ADDR   = 24'h000000;
    localparam logic [3:0]  USER_CEIL    = 4'h7;
    localparam logic [3:0]  TRAP_TOP_LVL = 4'hF;

    // ==========================================================
    // Timing: cycles from pending to request, and bus answer
    localparam int ENTRY_LATENCY = 1;
    localparam int BUS_LATENCY   = 1;
endpackage : vic_pkg

// [rtl/vic_top.sv]
/*
 Vectored interrupt controller: request flags, enables, priorities,
 trap status, arbitration and the registered request to the CPU.
 Assumes peripherals and CPU run on clk; the external request pin
 is asynchronous. Registers sit on an Avalon-MM slave, word indexed.
*/
`timescale 1ns/100ps
module vic_top
    import vic_pkg::*;
#(
    parameter int N = NUM_SRC
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               sys_rst,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0]  address,
    input  wire logic               read,
    input  wire logic               write,
    input  wire logic [DATA_W-1:0]  writedata,
    output logic      [DATA_W-1:0]  readdata,
    output logic                    waitrequest,
    // Event sources
    input  wire logic [N-1:0]       src_event,
    input  wire logic               external_request_zero,
    input  wire logic [NUM_TRAP-1:0] trap_event,
    // CPU core
    input  wire logic [LVL_W-1:0]   cpu_priority_level,
    output logic                    irq_req,
    output logic                    irq_is_trap,
    output logic      [VEC_W-1:0]   irq_vector_num,
    output logic      [LVL_W-1:0]   irq_level,
    output logic      [PC_W-1:0]    irq_vector_addr
);
    localparam int FREGS = (N + SRC_PER_REG - 1) / SRC_PER_REG;
    localparam int PREGS = (N + PRIO_PER_REG - 1) / PRIO_PER_REG;

    // ==========================================================
    // Helpers
    function automatic logic in_win(input logic [5:0] a,
                                    input logic [5:0] base,
                                    input int cnt);
        in_win = (a >= base) && (32'(a) < 32'(base) + cnt);
    endfunction : in_win

    function automatic logic [2:0] low_set(input logic [7:0] v);
        low_set = 3'h0;
        for (int k = 7; k >= 0; k--) begin
            if (v[k]) begin
                low_set = 3'(k);
            end
        end
    endfunction : low_set

    // ==========================================================
    // State
    logic [N-1:0]             flag;
    logic [N-1:0]             en;
    logic [N-1:0][PRIO_W-1:0] prio;
    logic [DATA_W-1:0]        ctrl_one;
    logic [DATA_W-1:0]        ctrl_two;
    logic [DATA_W-1:0]        pending_vector_reg;
    logic                     ack;
    logic [2:0]               pin_sync;

    logic [N-1:0]             next_flag;
    logic [N-1:0]             next_en;
    logic [N-1:0][PRIO_W-1:0] next_prio;

    // ==========================================================
    // Avalon handshake: one wait cycle, then the access completes
    wire acc     = read | write;
    wire wr_fire = write & ack;
    assign waitrequest = acc & ~ack;

    // Ack only at the completing edge; drops so next access waits
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack <= 1'b0;
        end else begin
            ack <= acc & ~ack;
        end
    end

    // ==========================================================
    // External pin: two flops, then edge on the synced copy
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_sync <= 3'h0;
        end else begin
            pin_sync <= {pin_sync[1:0], external_request_zero};
        end
    end

    wire         pin_rise = pin_sync[1] & ~pin_sync[2];
    wire [N-1:0] evt      = src_event | N'(pin_rise);

    // ==========================================================
    // Per-source flag, enable and priority field
    logic [FREGS*DATA_W-1:0] flag_pad;
    logic [FREGS*DATA_W-1:0] en_pad;
    logic [PREGS*DATA_W-1:0] prio_pad;

    generate
        for (genvar i = 0; i < N; i++) begin : g_src
            localparam logic [5:0] FR =
                6'(REG_FLAG_BASE + i / SRC_PER_REG);
            localparam logic [5:0] ER =
                6'(REG_EN_BASE + i / SRC_PER_REG);
            localparam logic [5:0] PR =
                6'(REG_PRIO_BASE + i / PRIO_PER_REG);
            localparam int B = i % SRC_PER_REG;
            localparam int P = (i % PRIO_PER_REG) * PRIO_STRIDE;
            wire wf = wr_fire && address == FR;
            wire we = wr_fire && address == ER;
            wire wp = wr_fire && address == PR;
            // Event beats a software clear in the same cycle
            assign next_flag[i] = (wf ? writedata[B] : flag[i])
                                  | evt[i];
            assign next_en[i]   = we ? writedata[B] : en[i];
            assign next_prio[i] = wp ? writedata[P +: PRIO_W]
                                     : prio[i];
            assign prio_pad[i*PRIO_STRIDE +: PRIO_STRIDE] =
                {1'b0, prio[i]};
        end
        for (genvar j = N; j < PREGS * PRIO_PER_REG; j++) begin : g_pad
            assign prio_pad[j*PRIO_STRIDE +: PRIO_STRIDE] = 4'h0;
        end
    endgenerate

    assign flag_pad = (FREGS*DATA_W)'(flag);
    assign en_pad   = (FREGS*DATA_W)'(en);

    // Reset clears every register; PC restart is the core's job
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flag <= '0;
            en   <= '0;
            prio <= '0;
        end else begin
            flag <= next_flag;
            en   <= next_en;
            prio <= next_prio;
        end
    end

    // ==========================================================
    // Control registers; trap status bits are sticky
    wire w_one = wr_fire && address == REG_CTRL_ONE;
    wire w_two = wr_fire && address == REG_CTRL_TWO;
    wire [7:0] trap_set = trap_event & TRAP_IMPL_MASK;
    wire [DATA_W-1:0] next_one =
        ((w_one ? writedata : ctrl_one) | DATA_W'(trap_set))
        & {1'b1, 7'h00, TRAP_IMPL_MASK};

    // Select bit resets clear, so the primary table is used
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_one <= CTRL_RESET;
            ctrl_two <= CTRL_RESET;
        end else begin
            ctrl_one <= next_one;
            if (w_two) begin
                // Only the select bit is kept; reserved bits read zero
                ctrl_two <= writedata & (DATA_W'(1) << ALT_SEL_BIT);
            end
        end
    end

    wire alt_table_select = ctrl_two[ALT_SEL_BIT];

    // ==========================================================
    // Pending sources and arbitration
    wire [N-1:0] pend;
    wire [N-1:0] vec_ok;
    generate
        for (genvar i = 0; i < N; i++) begin : g_pend
            // Level seven and priority zero both fail the compare
            assign vec_ok[i] = {1'b0, prio[i]} > cpu_priority_level;
        end
    endgenerate
    assign pend = flag & en & vec_ok;

    logic             u_win;
    logic [VEC_W-1:0] u_idx;
    logic [2:0]       u_lvl;

    vic_arbiter #(
        .N       (N)
    ) u_arb (
        .pend    (pend),
        .prio    (prio),
        .win     (u_win),
        .win_idx (u_idx),
        .win_lvl (u_lvl)
    );

    // Traps ignore enables and CPU level; lowest number first
    wire [7:0] trap_pend = ctrl_one[7:0] & TRAP_IMPL_MASK;
    wire       t_win     = |trap_pend;
    wire [2:0] t_idx     = low_set(trap_pend);
    wire       win_any   = t_win | u_win;

    wire [VEC_W-1:0] win_tbl = t_win ? {4'h0, t_idx}
                             : VEC_W'(u_idx + NUM_TRAP);
    wire [LVL_W-1:0] win_lvl = t_win ? TRAP_TOP_LVL - {1'b0, t_idx}
                             : {1'b0, u_lvl};

    logic [PC_W-1:0] win_addr;

    vic_vec_addr u_vec (
        .table_idx  (win_tbl),
        .alt_sel    (alt_table_select),
        .entry_addr (win_addr)
    );

    // ==========================================================
    // CPU request: one register stage, same for every source
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_req         <= 1'b0;
            irq_is_trap     <= 1'b0;
            irq_vector_num  <= '0;
            irq_level       <= '0;
            irq_vector_addr <= RESET_ADDR;
        end else begin
            irq_req         <= win_any;
            irq_is_trap     <= t_win;
            irq_vector_num  <= win_tbl;
            irq_level       <= win_lvl;
            irq_vector_addr <= win_addr;
        end
    end

    // Winner latch; holds last winner while nothing pends
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pending_vector_reg <= '0;
        end else if (win_any) begin
            pending_vector_reg <= {4'h0, win_lvl, 1'b0, win_tbl};
        end
    end

    // ==========================================================
    // Read mux; unmapped words read zero
    wire [5:0] f_off = address - REG_FLAG_BASE;
    wire [5:0] e_off = address - REG_EN_BASE;
    wire [5:0] p_off = address - REG_PRIO_BASE;
    wire [DATA_W-1:0] next_rdata =
        in_win(address, REG_FLAG_BASE, FREGS)
            ? flag_pad[f_off*DATA_W +: DATA_W] :
        in_win(address, REG_EN_BASE, FREGS)
            ? en_pad[e_off*DATA_W +: DATA_W] :
        in_win(address, REG_PRIO_BASE, PREGS)
            ? prio_pad[p_off*DATA_W +: DATA_W] :
        (address == REG_CTRL_ONE) ? ctrl_one :
        (address == REG_CTRL_TWO) ? ctrl_two :
        (address == REG_PENDING)  ? pending_vector_reg :
        16'h0000;

    // Data captured in the wait cycle, stands at the completing edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            readdata <= '0;
        end else if (read && !ack) begin
            readdata <= next_rdata;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_flag_sticky: assert property (
        flag[0] && !(wr_fire && address == REG_FLAG_BASE)
        |=> flag[0])
        else $error("flag 0 dropped without a software write");

    chk_event_sets: assert property (
        src_event[3] |=> flag[3] ##0 (flag[3] || sys_rst))
        else $error("event did not set its flag");

    chk_entry_fixed: assert property (
        win_any |=> irq_req ##1 1'b1)
        else $error("request not raised one cycle after pending");

    chk_idle_quiet: assert property (
        !win_any |=> !irq_req)
        else $error("request without any pending source");

    chk_level_above: assert property (
        irq_req && !irq_is_trap
        |-> irq_level > $past(cpu_priority_level) && irq_level != 4'h0)
        else $error("user request at or below CPU level");

    chk_ceiling: assert property (
        cpu_priority_level >= USER_CEIL && !t_win |=> !irq_req)
        else $error("user request taken at CPU level seven");

    chk_table_addr: assert property (
        irq_req |-> irq_vector_addr == PRIMARY_BASE
            + ($past(alt_table_select) ? ALT_OFFSET : 24'h000000)
            + {16'h0000, irq_vector_num, 1'b0})
        else $error("vector address does not match table");

    chk_trap_first: assert property (
        t_win |=> irq_req && irq_is_trap
            && irq_vector_num < 7'(NUM_TRAP))
        else $error("pending trap not presented first");

    chk_vec0_wins: assert property (
        pend[0] && prio[0] == 3'h7 && !t_win
        |=> irq_vector_num == 7'h08)
        else $error("vector 0 lost at top level");

    chk_timer_one: assert property (
        irq_req && irq_vector_num == 7'h0B && !$past(alt_table_select)
        |-> irq_vector_addr == 24'h00001A)
        else $error("timer one vector address wrong");

    chk_pend_latch: assert property (
        win_any |=> pending_vector_reg[6:0] == irq_vector_num
            ##2 1'b1)
        else $error("pending register not latched");

    cov_trap_taken: cover property (t_win ##1 irq_is_trap);
    cov_alt_taken:  cover property (irq_req && alt_table_select);
    cov_vec0:       cover property (irq_req && irq_vector_num == 7'h08);
    cov_sw_clear:   cover property (flag[0] ##1 !flag[0]);
endmodule : vic_top

// [rtl/vic_vec_addr.sv]
/*
 Vector entry address from table index and table select.
 Assumes an index already bounded to the table size.
*/
`timescale 1ns/100ps
module vic_vec_addr
    import vic_pkg::*;
(
    // Selection
    input  wire logic [VEC_W-1:0] table_idx,
    input  wire logic             alt_sel,
    // Result
    output logic      [PC_W-1:0]  entry_addr
);
    // ==========================================================
    // Address arithmetic
    wire [PC_W-1:0] idx_off = {16'h0000, table_idx, 1'b0};
    wire [PC_W-1:0] tbl_off = alt_sel ? ALT_OFFSET : 24'h000000;

    // Two words per entry, one 24-bit address each
    assign entry_addr = PRIMARY_BASE + tbl_off + idx_off;
endmodule : vic_vec_addr
